// ==== logic/afecfg_pkg.sv ====
// Shared constants of the front-end configuration link: instruction layout,
// register addresses, reset values, unlock key and link timing.
// Assumes a 100 MHz system clock on both ends of the serial link.
package afecfg_pkg;

	// Instruction byte layout.
	localparam int INSTR_READ_BIT = 7;
	localparam int INSTR_RSVD_HI = 6;
	localparam int INSTR_RSVD_LO = 4;
	localparam int INSTR_ADDR_HI = 3;

	// Register addresses inside the front end.
	localparam logic [3:0] ADDR_DEVICE_CONFIGURATION = 4'h0;
	localparam logic [3:0] ADDR_OFFSET_DAC_SETTING = 4'h1;
	localparam logic [3:0] ADDR_READBACK_UNLOCK_KEY = 4'hF;

	// Values after reset.
	localparam logic [7:0] RST_DEVICE_CONFIGURATION = 8'h00;
	localparam logic [7:0] RST_OFFSET_DAC_SETTING = 8'h80;
	localparam logic [7:0] RST_READBACK_UNLOCK_KEY = 8'h00;
	localparam logic [7:0] READ_FILL_VALUE = 8'h00;

	// Two-byte readback key, first and second byte.
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hFE;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hED;

	// Field positions of the device configuration register.
	localparam int CFG_INPUT_SEL_BIT = 7;
	localparam int CFG_FIRST_AMP_BIT = 6;
	localparam int CFG_SECOND_AMP_BIT = 5;
	localparam int CFG_EXT_FILTER_BIT = 4;
	localparam int CFG_COMMON_LEVEL_BIT = 3;
	localparam int CFG_SECOND_GAIN_HI = 2;
	localparam int CFG_SECOND_GAIN_LO = 1;
	localparam int CFG_FIRST_GAIN_BIT = 0;

	// Offset DAC transfer: output shift per code step in microvolts.
	localparam int DAC_MID_CODE = 128;
	localparam int DAC_STEP_UV = -33800;

	// Frame layout in serial clock edges.
	localparam logic [4:0] BITS_PER_BYTE = 5'h08;
	localparam logic [4:0] BITS_PER_FRAME = 5'h10;

	// Link timing.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SDIO_HOLD_NS = 10;
	localparam logic [7:0] SCLK_HALF_CYCLES =
		8'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [7:0] SDIO_HOLD_CYCLES =
		8'((SDIO_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Controller register offsets on APB.
	localparam logic [7:0] HOST_REG_COMMAND = 8'h00;
	localparam logic [7:0] HOST_REG_STATUS = 8'h04;
	localparam logic [7:0] HOST_REG_READ_DATA = 8'h08;
	localparam int HOST_STATUS_BUSY_BIT = 0;
	localparam int HOST_STATUS_LOCKED_READ_BIT = 1;

endpackage

// ==== logic/afecfg_link_if.sv ====
// Serial link between the front-end register bank and its controller.
// The data line is shared; its level is resolved here from both enables,
// with a weak pull-up when nobody drives it.
`timescale 1ns/1ns
interface afecfg_link_if;
	logic sclk;
	logic csN;
	logic hostSdo;
	logic hostSdoOe;
	logic devSdo;
	logic devSdoOe;
	logic sdio;

	// Wire level of the shared data line.
	assign sdio = devSdoOe ? devSdo : (hostSdoOe ? hostSdo : 1'b1);

	modport device (input sclk, input csN, input sdio,
		output devSdo, output devSdoOe);
	modport host (output sclk, output csN, output hostSdo,
		output hostSdoOe, input sdio);
endinterface

// ==== logic/afecfg_device.sv ====
// Register bank of the thermopile front end behind its serial link.
// Assumes the link pins are asynchronous to clk_sys and slow enough that
// each serial clock level lasts at least four system clocks.
// Functional notes
// - Instruction bit seven: zero write, one read.
// - Master sends zeros in bits six-four.
// - Low four instruction bits address one register.
// - Configuration at zero, resets zero, locked reads.
// - Offset DAC at one, resets to 128.
// - Unlock key at fifteen, write-only.
// - Keys FE then ED enter readback mode.
// - Other unlock writes leave readback mode.
// - Configuration bit seven picks input channel.
// - Bits six, five power amplifier stages.
// - Bit four routes through external filter.
// - DAC shifts output minus 33.8 mV/step.
// - Master writes only documented addresses.
// - One command plus one data byte.
// - Chip select high aborts, low restarts.
// - Master releases data, idles clock high.
// - Unlocked reads drive register onto data.
`timescale 1ns/1ns
module afecfg_device
(
	input wire logic clk_sys,
	input wire logic rstn,
	afecfg_link_if.device link,
	output logic inputChannelSelect,
	output logic firstAmpStageEn,
	output logic secondAmpStageEn,
	output logic externalFilterRoute,
	output logic commonLevelSelect,
	output logic [1:0] secondStageGain,
	output logic firstStageGain,
	output logic [7:0] offsetDacCode,
	output logic signed [23:0] offsetShiftUv,
	output logic readbackUnlocked
);
	typedef enum logic [0:0] {DEV_COMMAND, DEV_DATA} afecfg_dev_state_type;

	// Synchroniser stages; stage one feeds only stage two.
	logic sclkS1_q, sclkS2_q, sclkS3_q;
	logic csS1_q, csS2_q;
	logic sdioS1_q, sdioS2_q;

	afecfg_dev_state_type state_q, state_d;
	logic [4:0] bitCnt_q, bitCnt_d;
	logic [7:0] inShift_q, inShift_d;
	logic [7:0] instr_q, instr_d;
	logic [7:0] outShift_q, outShift_d;
	logic sdo_q, sdo_d;
	logic sdoOe_q, sdoOe_d;
	logic [7:0] config_q, config_d;
	logic [7:0] dac_q, dac_d;
	logic [7:0] key_q, key_d;
	logic unlocked_q, unlocked_d;
	logic signed [23:0] shift_q, shift_d;
	logic sclkRise, sclkFall;
	logic [7:0] rxByte;
	logic [7:0] readValue;

	// Two flip-flops on every pin before any logic reads it.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			sclkS1_q <= 1'b1;
			sclkS2_q <= 1'b1;
			sclkS3_q <= 1'b1;
			csS1_q <= 1'b1;
			csS2_q <= 1'b1;
			sdioS1_q <= 1'b1;
			sdioS2_q <= 1'b1;
		end
		else
		begin
			sclkS1_q <= link.sclk;
			sclkS2_q <= sclkS1_q;
			sclkS3_q <= sclkS2_q;
			csS1_q <= link.csN;
			csS2_q <= csS1_q;
			sdioS1_q <= link.sdio;
			sdioS2_q <= sdioS1_q;
		end
	end

	// Edges of the serial clock, seen only while the chip is selected.
	assign sclkRise = !csS2_q && sclkS2_q && !sclkS3_q;
	assign sclkFall = !csS2_q && !sclkS2_q && sclkS3_q;
	assign rxByte = {inShift_q[6:0], sdioS2_q};

	// Read multiplexer; the key register and holes read as a fixed fill.
	// A locked bank never drives this value, so the fill is seen unlocked.
	always_comb
	begin
		readValue = afecfg_pkg::READ_FILL_VALUE;
		unique case (instr_q[afecfg_pkg::INSTR_ADDR_HI:0])
			afecfg_pkg::ADDR_DEVICE_CONFIGURATION: readValue = config_q;
			afecfg_pkg::ADDR_OFFSET_DAC_SETTING: readValue = dac_q;
			default: readValue = afecfg_pkg::READ_FILL_VALUE;
		endcase
	end

	// Frame sequencing, register writes, key tracking and readback drive.
	always_comb
	begin
		int diff;
		diff = 0;
		state_d = state_q;
		bitCnt_d = bitCnt_q;
		inShift_d = inShift_q;
		instr_d = instr_q;
		outShift_d = outShift_q;
		sdo_d = sdo_q;
		sdoOe_d = sdoOe_q;
		config_d = config_q;
		dac_d = dac_q;
		key_d = key_q;
		unlocked_d = unlocked_q;
		if (csS2_q)
		begin
			state_d = DEV_COMMAND;
			bitCnt_d = 5'h00;
			sdoOe_d = 1'b0;
		end
		else if (sclkRise)
		begin
			inShift_d = rxByte;
			bitCnt_d = bitCnt_q + 5'h01;
			if (bitCnt_q == afecfg_pkg::BITS_PER_BYTE - 5'h01)
			begin
				instr_d = rxByte;
				state_d = DEV_DATA;
			end
			else if (bitCnt_q == afecfg_pkg::BITS_PER_FRAME - 5'h01)
			begin
				// Frame complete; a tied-low select starts the next one.
				state_d = DEV_COMMAND;
				bitCnt_d = 5'h00;
				sdoOe_d = 1'b0;
				if (!instr_q[afecfg_pkg::INSTR_READ_BIT])
				begin
					// Undocumented addresses ignore writes.
					unique case (instr_q[afecfg_pkg::INSTR_ADDR_HI:0])
						afecfg_pkg::ADDR_DEVICE_CONFIGURATION: config_d = rxByte;
						afecfg_pkg::ADDR_OFFSET_DAC_SETTING: dac_d = rxByte;
						afecfg_pkg::ADDR_READBACK_UNLOCK_KEY:
						begin
							key_d = rxByte;
							unlocked_d = (key_q == afecfg_pkg::UNLOCK_KEY_FIRST) &&
								(rxByte == afecfg_pkg::UNLOCK_KEY_SECOND);
						end
						default: ;
					endcase
				end
			end
		end
		else if (sclkFall && state_q == DEV_DATA && unlocked_q &&
			instr_q[afecfg_pkg::INSTR_READ_BIT])
		begin
			if (bitCnt_q == afecfg_pkg::BITS_PER_BYTE)
			begin
				sdo_d = readValue[7];
				outShift_d = {readValue[6:0], 1'b0};
				sdoOe_d = 1'b1;
			end
			else
			begin
				sdo_d = outShift_q[7];
				outShift_d = {outShift_q[6:0], 1'b0};
			end
		end
		if (!unlocked_q)
		begin
			sdoOe_d = 1'b0;
		end
		diff = int'(dac_d) - afecfg_pkg::DAC_MID_CODE;
		shift_d = 24'(afecfg_pkg::DAC_STEP_UV * diff);
	end

	// Registers of the frame logic and of the bank.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			state_q <= DEV_COMMAND;
			bitCnt_q <= 5'h00;
			inShift_q <= 8'h00;
			instr_q <= 8'h00;
			outShift_q <= 8'h00;
			sdo_q <= 1'b0;
			sdoOe_q <= 1'b0;
			config_q <= afecfg_pkg::RST_DEVICE_CONFIGURATION;
			dac_q <= afecfg_pkg::RST_OFFSET_DAC_SETTING;
			key_q <= afecfg_pkg::RST_READBACK_UNLOCK_KEY;
			unlocked_q <= 1'b0;
			shift_q <= 24'h000000;
		end
		else
		begin
			state_q <= state_d;
			bitCnt_q <= bitCnt_d;
			inShift_q <= inShift_d;
			instr_q <= instr_d;
			outShift_q <= outShift_d;
			sdo_q <= sdo_d;
			sdoOe_q <= sdoOe_d;
			config_q <= config_d;
			dac_q <= dac_d;
			key_q <= key_d;
			unlocked_q <= unlocked_d;
			shift_q <= shift_d;
		end
	end

	assign link.devSdo = sdo_q;
	assign link.devSdoOe = sdoOe_q;

	// Analog controls straight from the bank, so they never glitch.
	// input channel
	assign inputChannelSelect = config_q[afecfg_pkg::CFG_INPUT_SEL_BIT];
	assign firstAmpStageEn = config_q[afecfg_pkg::CFG_FIRST_AMP_BIT];
	assign secondAmpStageEn = config_q[afecfg_pkg::CFG_SECOND_AMP_BIT];
	assign externalFilterRoute = config_q[afecfg_pkg::CFG_EXT_FILTER_BIT];
	assign commonLevelSelect = config_q[afecfg_pkg::CFG_COMMON_LEVEL_BIT];
	assign secondStageGain =
		config_q[afecfg_pkg::CFG_SECOND_GAIN_HI:afecfg_pkg::CFG_SECOND_GAIN_LO];
	assign firstStageGain = config_q[afecfg_pkg::CFG_FIRST_GAIN_BIT];
	assign offsetDacCode = dac_q;
	assign offsetShiftUv = shift_q;
	assign readbackUnlocked = unlocked_q;

endmodule

// ==== logic/afecfg_host.sv ====
// Controller end of the front-end link: an APB slave whose command register
// launches one serial frame, built from a divided system clock.
// Assumes software waits for the busy bit to clear between commands.
`timescale 1ns/1ns
module afecfg_host
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	afecfg_link_if.host link
);
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP}
		afecfg_host_state_type;

	logic sdioS1_q, sdioS2_q;
	afecfg_host_state_type state_q, state_d;
	logic [7:0] tick_q, tick_d;
	logic [4:0] bitCnt_q, bitCnt_d;
	logic [15:0] cmd_q, cmd_d;
	logic [15:0] txShift_q, txShift_d;
	logic [7:0] rx_q, rx_d;
	logic sclk_q, sclk_d;
	logic csN_q, csN_d;
	logic sdo_q, sdo_d;
	logic sdoOe_q, sdoOe_d;
	logic [31:0] prdata_q, prdata_d;
	logic isRead, halfDone, mapped, start;

	// Returned data line passes two flip-flops.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			sdioS1_q <= 1'b1;
			sdioS2_q <= 1'b1;
		end
		else
		begin
			sdioS1_q <= link.sdio;
			sdioS2_q <= sdioS1_q;
		end
	end

	// Bus decode: zero wait states, unmapped addresses answer with an error.
	assign mapped = paddr == afecfg_pkg::HOST_REG_COMMAND ||
		paddr == afecfg_pkg::HOST_REG_STATUS ||
		paddr == afecfg_pkg::HOST_REG_READ_DATA;
	assign pready = psel && penable;
	assign pslverr = psel && penable && !mapped;
	assign start = psel && penable && pwrite &&
		paddr == afecfg_pkg::HOST_REG_COMMAND && state_q == H_IDLE;
	assign isRead = cmd_q[8 + afecfg_pkg::INSTR_READ_BIT];
	assign halfDone = tick_q == afecfg_pkg::SCLK_HALF_CYCLES - 8'h01;

	// Frame generator; the clock idles high so reads are legal.
	always_comb
	begin
		state_d = state_q;
		tick_d = halfDone ? 8'h00 : tick_q + 8'h01;
		bitCnt_d = bitCnt_q;
		cmd_d = cmd_q;
		txShift_d = txShift_q;
		rx_d = rx_q;
		sclk_d = sclk_q;
		csN_d = csN_q;
		sdo_d = sdo_q;
		sdoOe_d = sdoOe_q;
		prdata_d = prdata_q;
		unique case (state_q)
			H_IDLE:
			begin
				tick_d = 8'h00;
				if (start)
				begin
					cmd_d = pwdata[15:0];
					cmd_d[8 + afecfg_pkg::INSTR_RSVD_HI:
						8 + afecfg_pkg::INSTR_RSVD_LO] = 3'h0;
					txShift_d = cmd_d;
					bitCnt_d = 5'h00;
					csN_d = 1'b0;
					state_d = H_SETUP;
				end
			end
			H_SETUP, H_HIGH:
			begin
				// On reads, release the line one hold time after the last command bit.
				// release data, clock high
				if (state_q == H_HIGH && isRead && tick_q ==
					afecfg_pkg::SDIO_HOLD_CYCLES - 8'h01 &&
					bitCnt_q == afecfg_pkg::BITS_PER_BYTE - 5'h01)
					sdoOe_d = 1'b0;
				if (halfDone)
				begin
					if (state_q == H_HIGH &&
						bitCnt_q == afecfg_pkg::BITS_PER_FRAME - 5'h01)
						state_d = H_HOLD;
					else
					begin
						if (state_q == H_HIGH)
							bitCnt_d = bitCnt_q + 5'h01;
						sclk_d = 1'b0;
						sdo_d = txShift_q[15];
						txShift_d = {txShift_q[14:0], 1'b0};
						sdoOe_d = !(isRead && (state_q == H_HIGH) &&
							bitCnt_q >= afecfg_pkg::BITS_PER_BYTE - 5'h01);
						state_d = H_LOW;
					end
				end
			end
			H_LOW:
			begin
				if (halfDone)
				begin
					sclk_d = 1'b1;
					if (isRead && bitCnt_q >= afecfg_pkg::BITS_PER_BYTE)
						rx_d = {rx_q[6:0], sdioS2_q};
					state_d = H_HIGH;
				end
			end
			H_HOLD:
			begin
				sdoOe_d = 1'b0;
				if (halfDone)
				begin
					csN_d = 1'b1;
					state_d = H_GAP;
				end
			end
			H_GAP:
			begin
				if (halfDone)
					state_d = H_IDLE;
			end
		endcase
		// Read data is latched in the setup cycle, ready for the access phase.
		if (psel && !penable)
		begin
			prdata_d = 32'h00000000;
			if (paddr == afecfg_pkg::HOST_REG_COMMAND)
				prdata_d[15:0] = cmd_d;
			else if (paddr == afecfg_pkg::HOST_REG_STATUS)
			begin
				prdata_d[afecfg_pkg::HOST_STATUS_BUSY_BIT] = state_q != H_IDLE;
				prdata_d[afecfg_pkg::HOST_STATUS_LOCKED_READ_BIT] =
					isRead && rx_q == 8'hFF;
			end
			else if (paddr == afecfg_pkg::HOST_REG_READ_DATA)
				prdata_d[7:0] = rx_d;
		end
	end

	// Registers of the controller.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			state_q <= H_IDLE;
			tick_q <= 8'h00;
			bitCnt_q <= 5'h00;
			cmd_q <= 16'h0000;
			txShift_q <= 16'h0000;
			rx_q <= 8'h00;
			sclk_q <= 1'b1;
			csN_q <= 1'b1;
			sdo_q <= 1'b0;
			sdoOe_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			state_q <= state_d;
			tick_q <= tick_d;
			bitCnt_q <= bitCnt_d;
			cmd_q <= cmd_d;
			txShift_q <= txShift_d;
			rx_q <= rx_d;
			sclk_q <= sclk_d;
			csN_q <= csN_d;
			sdo_q <= sdo_d;
			sdoOe_q <= sdoOe_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign link.sclk = sclk_q;
	assign link.csN = csN_q;
	assign link.hostSdo = sdo_q;
	assign link.hostSdoOe = sdoOe_q;

endmodule

// ==== test/afecfg_link_asserts.sv ====
// Timing checks on the serial link between controller and register bank.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module afecfg_link_asserts
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic csN,
	input wire logic hostSdo,
	input wire logic hostSdoOe,
	input wire logic devSdo,
	input wire logic devSdoOe,
	input wire logic sdio
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// Each serial clock level lasts a half period of eight clocks.
	sequence low_rest;
		(!sclk)[*7];
	endsequence
	sequence high_rest;
		sclk[*7];
	endsequence

	no_contention_a: assert property (!(hostSdoOe && devSdoOe))
		else $error("both ends drive the data line");
	idle_high_a: assert property (csN |-> sclk)
		else $error("serial clock not idle high");
	deselect_quiet_a: assert property (csN[*5] |-> !devSdoOe)
		else $error("bank drives while deselected");
	low_half_a: assert property ($fell(sclk) |=> low_rest)
		else $error("serial clock low half too short");
	high_half_a: assert property ($rose(sclk) |=> high_rest)
		else $error("serial clock high half too short");
	enable_on_fall_a: assert property ($rose(devSdoOe) |-> !sclk)
		else $error("bank enabled outside a low half");
	read_hold_a: assert property ($rose(devSdoOe) |-> devSdoOe[*8])
		else $error("bank released read data early");
	// Both ends may only move data while the serial clock is low.
	dev_data_low_a: assert property (devSdoOe && $past(devSdoOe)
		&& $changed(devSdo) |-> !sclk)
		else $error("bank data moved while clock high");
	host_data_low_a: assert property (!csN && hostSdoOe
		&& $past(hostSdoOe) && $changed(hostSdo) |-> !sclk)
		else $error("host data moved while clock high");
endmodule

// ==== test/tb.sv ====
// Bench: controller and register bank face each other over the link.
// Software side is driven over APB; the bank's outputs are observed.
`timescale 1ns/1ns
module tb;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic inSel, amp1, amp2, extF, cmnL, first_stage_gain, unl;
	logic [1:0] second_stage_gain;
	logic [7:0] dac;
	logic signed [23:0] shiftUv;
	logic [15:0] wireBits = 16'h0000;
	int wireCount = 0;
	logic sclkPrev = 1'b1;
	logic csPrev = 1'b1;
	logic devSeen = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic err;
	logic [7:0] cfgTab [4] = '{8'h06, 8'h00, 8'hA5, 8'h5A};
	logic [7:0] dacTab [3] = '{8'h00, 8'hFF, 8'h3C};
	logic [3:0] rdAddr [3] = '{4'h0, 4'h1, 4'hF};
	logic [7:0] rdExp [3] = '{8'h5A, 8'h3C, 8'h00};

	afecfg_link_if link();
	afecfg_host afecfg_host_inst (.clk_sys(clk_sys), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.host));
	afecfg_device afecfg_device_inst (.clk_sys(clk_sys), .rstn(rstn),
		.link(link.device), .inputChannelSelect(inSel),
		.firstAmpStageEn(amp1), .secondAmpStageEn(amp2),
		.externalFilterRoute(extF), .commonLevelSelect(cmnL),
		.secondStageGain(second_stage_gain), .firstStageGain(first_stage_gain),
		.offsetDacCode(dac), .offsetShiftUv(shiftUv),
		.readbackUnlocked(unl));
	afecfg_link_asserts afecfg_link_asserts_inst (.clk_sys(clk_sys),
		.rstn(rstn), .sclk(link.sclk), .csN(link.csN),
		.hostSdo(link.hostSdo), .hostSdoOe(link.hostSdoOe),
		.devSdo(link.devSdo), .devSdoOe(link.devSdoOe), .sdio(link.sdio));

	// Free-running 100 MHz system clock.
	always #5 clk_sys = ~clk_sys;

	// Record wire bits at each serial clock rise, and any bank drive.
	// Both records restart when chip select falls, so they survive the
	// deselect that ends a frame and can be checked afterwards.
	always @(posedge clk_sys)
	begin
		sclkPrev <= link.sclk;
		csPrev <= link.csN;
		if (link.csN === 1'b0 && csPrev === 1'b1)
		begin
			wireCount <= 0;
			devSeen <= 1'b0;
		end
		else
		begin
			if (link.devSdoOe === 1'b1)
				devSeen <= 1'b1;
			if (link.sclk === 1'b1 && sclkPrev === 1'b0)
			begin
				wireBits <= {wireBits[14:0], link.sdio};
				wireCount <= wireCount + 1;
			end
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 20)
		begin
			fail_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Launch one frame, then poll busy; rd keeps the final status.
	task automatic frame(input logic [7:0] ins, input logic [7:0] dat);
		int n;
		apb(1'b1, afecfg_pkg::HOST_REG_COMMAND, {16'h0000, ins, dat});
		n = 0;
		rd = 32'h00000001;
		while (rd[afecfg_pkg::HOST_STATUS_BUSY_BIT] !== 1'b0 && n < 300)
		begin
			apb(1'b0, afecfg_pkg::HOST_REG_STATUS, 32'h00000000);
			n++;
		end
		if (n >= 300)
		begin
			fail_count++;
			final_report();
		end
	endtask

	task automatic reset_checks();
		check("cfg", 32'({inSel, amp1, amp2, extF, cmnL, second_stage_gain, first_stage_gain}),
			32'(afecfg_pkg::RST_DEVICE_CONFIGURATION));
		check("dac", 32'(dac), 32'(afecfg_pkg::RST_OFFSET_DAC_SETTING));
		check("shift", 32'(shiftUv), 32'h00000000);
		check("unlocked", 32'(unl), 32'h00000000);
	endtask

	// Main sequence: reset, locked read, writes, unlock, reads, relock.
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		reset_checks();
		frame(8'h80, 8'h00);
		check("locked drive", 32'(devSeen), 32'h0);
		check("status", rd, 32'h00000002);
		check("cmd on wire", 32'(wireBits[15:8]), 32'h80);
		check("bit count", 32'(wireCount), 32'd16);
		foreach (cfgTab[i])
		begin
			frame({4'h0, afecfg_pkg::ADDR_DEVICE_CONFIGURATION}, cfgTab[i]);
			check("wire", 32'(wireBits), 32'({8'h00, cfgTab[i]}));
			check("inSel", 32'(inSel), 32'(cfgTab[i][7]));
			check("amp1", 32'(amp1), 32'(cfgTab[i][6]));
			check("amp2", 32'(amp2), 32'(cfgTab[i][5]));
			check("extF", 32'(extF), 32'(cfgTab[i][4]));
			check("cmnL", 32'(cmnL), 32'(cfgTab[i][3]));
			check("second_stage_gain", 32'(second_stage_gain), 32'(cfgTab[i][2:1]));
			check("first_stage_gain", 32'(first_stage_gain), 32'(cfgTab[i][0]));
		end
		foreach (dacTab[i])
		begin
			frame({4'h0, afecfg_pkg::ADDR_OFFSET_DAC_SETTING}, dacTab[i]);
			check("dac", 32'(dac), 32'(dacTab[i]));
			check("shift", 32'(shiftUv),
				32'(-33800 * (int'(dacTab[i]) - 128)));
		end
		// Reserved bits set by software go out as zero; address one
		// must leave the configuration register alone.
		frame(8'h71, 8'h3C);
		check("rsvd zero", 32'(wireBits[15:8]), 32'h01);
		check("cfg kept", 32'(second_stage_gain), 32'h1);
		check("dac kept", 32'(dac), 32'h3C);
		apb(1'b1, 8'h0C, 32'h00001234);
		check("apb err", 32'(err), 32'h1);
		apb(1'b0, 8'h0C, 32'h00000000);
		check("apb rd", rd, 32'h00000000);
		frame(8'h0F, afecfg_pkg::UNLOCK_KEY_FIRST);
		frame(8'h0F, afecfg_pkg::UNLOCK_KEY_SECOND);
		check("unlocked", 32'(unl), 32'h1);
		foreach (rdAddr[i])
		begin
			frame({4'h8, rdAddr[i]}, 8'h00);
			check("bank drove", 32'(devSeen), 32'h1);
			check("rd wire", 32'(wireBits[7:0]), 32'(rdExp[i]));
			apb(1'b0, afecfg_pkg::HOST_REG_READ_DATA, 32'h00000000);
			check("rd byte", rd, 32'(rdExp[i]));
		end
		frame(8'h0F, afecfg_pkg::UNLOCK_KEY_FIRST);
		frame(8'h0F, 8'h00);
		check("relocked", 32'(unl), 32'h0);
		frame(8'h0F, afecfg_pkg::UNLOCK_KEY_SECOND);
		check("lone key", 32'(unl), 32'h0);
		// A second reset in mid-run must restore every value.
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		reset_checks();
		final_report();
	end
endmodule
